/* File: exec_error_classifier.sv */
// Execution error classifier: takes one parsed, valid message, waits for evaluation,
// then reports at most one execution code and the status bit that goes with it.
// Assumes all inputs come from logic on mclk, so none is synchronised here.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module execution_error_classifier
(
   // Clock and reset
   input  wire                          mclk,
   input  wire                          rst_b,
   // Parsed message from the command parser
   input  wire                          req_valid,
   input  wire exec_pkg::exec_req_t     req,
   // Rounding and expression evaluation finished for the held message
   input  wire                          eval_done,
   // Instrument levels
   input  wire exec_pkg::exec_cond_t    cond,
   // Status and error reporting
   output logic                         busy,
   output logic                         err_valid,
   output logic [`CODE_W-1:0]           err_code,
   output logic [`ESR_W-1:0]            esr_set,
   output logic                         cmd_err,
   output logic                         get_dropped,
   output logic                         exec_ok
);

   typedef enum logic [0:0] {S_IDLE, S_WAIT} state_t;

   state_t                    state;
   state_t                    next_state;
   exec_pkg::exec_req_t       held;
   exec_pkg::exec_verdict_t   verdict;

   // ****************************************************************
   // Message hand-off
   // ****************************************************************

   // A message arriving while one is held is ignored; the parser must watch busy.
   wire take   = (state == S_IDLE) & req_valid;
   wire finish = (state == S_WAIT) & eval_done;

   assign next_state = take   ? S_WAIT :
                       finish ? S_IDLE : state;

   // State register.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   // The message is latched so later parser activity cannot disturb the verdict.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         held <= '0;
      else if (take)
         held <= req;
   end

   // ****************************************************************
   // Classification
   // ****************************************************************

   exec_code_picker u_picker
   (
      .req     (held),
      .cond    (cond),
      .verdict (verdict)
   );

   // Results are sampled only once evaluation is over, so a rounded value
   // is judged in its final form and never raises an error on its own.
   wire                 next_err   = finish & verdict.exec_err;
   wire [`CODE_W-1:0]   next_code  = next_err ? verdict.code : `CODE_NONE;
   wire [`ESR_W-1:0]    next_esr   = next_err ? `ESR_EXEC_MASK : `ESR_NONE;
   wire                 next_cmd   = finish & verdict.cmd_err;
   wire                 next_get   = finish & verdict.get_dropped;
   wire                 next_ok    = finish & ~verdict.exec_err & ~verdict.cmd_err;
   wire                 next_busy  = (next_state == S_WAIT);

   // Report register: every output is a pulse of one cycle except busy.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         err_valid   <= 1'b0;
         err_code    <= `CODE_NONE;
         esr_set     <= `ESR_NONE;
         cmd_err     <= 1'b0;
         get_dropped <= 1'b0;
         exec_ok     <= 1'b0;
         busy        <= 1'b0;
      end
      else
      begin
         err_valid   <= next_err;
         err_code    <= next_code;
         esr_set     <= next_esr;
         cmd_err     <= next_cmd;
         get_dropped <= next_get;
         exec_ok     <= next_ok;
         busy        <= next_busy;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_taken;
      (state == S_IDLE) && req_valid;
   endsequence

   sequence s_evaluated;
      (state == S_WAIT) && eval_done;
   endsequence

   sequence s_held_cond(logic c);
      (state == S_WAIT) && eval_done && c;
   endsequence

   a_code_range: assert property (
      err_valid |-> ($signed(err_code) >= $signed(`CODE_MIN))
                    && ($signed(err_code) <= $signed(`CODE_MAX)))
      else $error("Execution code outside its range.");

   a_esr_bit: assert property (
      err_valid == esr_set[`ESR_EXEC_BIT]
      && (esr_set & ~`ESR_EXEC_MASK) == `ESR_NONE)
      else $error("Status bit does not track the execution error.");

   a_after_eval: assert property (
      err_valid |-> $past(eval_done) && $past(busy))
      else $error("Error reported before evaluation completed.");

   a_class_exclusive: assert property (
      !(err_valid && cmd_err))
      else $error("Event reported in two classes.");

   a_single_report: assert property (
      s_taken ##1 s_evaluated |=> !busy ##1 !err_valid)
      else $error("Message reported more than once.");

   a_local_code: assert property (
      s_held_cond(held.local_blocked && cond.hard_local
                  && (cond.trig_capable || !(held.is_trg || held.is_get)))
      |=> err_valid && err_code == `CODE_LOCAL)
      else $error("Hard local block not coded as -201.");

   a_protect_code: assert property (
      s_held_cond(held.pw_protected && !cond.cmd_enabled && !held.local_blocked
                  && (cond.trig_capable || !(held.is_trg || held.is_get)))
      |=> err_valid && err_code == `CODE_PROTECTED)
      else $error("Protected command not coded as -203.");

   a_trig_code: assert property (
      s_held_cond((held.is_trg || held.is_trig_sig) && cond.trig_capable
                  && !cond.trig_ready && !held.local_blocked && !held.pw_protected)
      |=> err_valid && err_code == `CODE_TRIG_IGN)
      else $error("Ignored trigger not coded as -211.");

   a_dt0_trigger: assert property (
      s_held_cond((held.is_trg || held.is_get) && !cond.trig_capable)
      |=> !err_valid ##0 (cmd_err == $past(held.is_trg)))
      else $error("Trigger on a device without triggers misclassified.");

   a_init_code: assert property (
      s_held_cond(held.is_init && cond.meas_busy && !held.local_blocked
                  && !held.pw_protected && !(held.is_trg || held.is_get
                  || held.is_trig_sig))
      |=> err_valid && err_code == `CODE_INIT_IGN)
      else $error("Busy measurement start not coded as -213.");

   a_range_code: assert property (
      s_held_cond(held.param_range && !held.param_conflict && !held.local_blocked
                  && !held.pw_protected && !held.is_init && !held.is_get
                  && !held.is_trg && !held.is_trig_sig)
      |=> err_valid && err_code == `CODE_RANGE)
      else $error("Out of range value not coded as -222.");

   a_generic_code: assert property (
      err_valid && err_code == `CODE_GENERIC
      |-> $past(held.device_cond) && !$past(held.param_other))
      else $error("Generic code used where a specific one applied.");

   // Messages with no condition ranked above the parameter codes, so one of those must win.
   wire plain_param = !held.local_blocked && !held.pw_protected && !held.is_init
                      && !held.is_get && !held.is_trg && !held.is_trig_sig;

   a_conflict_code: assert property (
      s_held_cond(held.param_conflict && plain_param)
      |=> err_valid && err_code == `CODE_CONFLICT)
      else $error("Settings clash not coded as -221.");

   a_list_code: assert property (
      s_held_cond(held.param_list && !held.param_conflict && !held.param_range
                  && plain_param)
      |=> err_valid && err_code == `CODE_ILLEGAL)
      else $error("Unlisted choice not coded as -224.");

   a_param_code: assert property (
      s_held_cond(held.param_other && !held.param_conflict && !held.param_range
                  && !held.param_list && plain_param)
      |=> err_valid && err_code == `CODE_PARAM)
      else $error("Plain parameter fault not coded as -220.");

   a_get_drop: assert property (
      s_held_cond(held.is_get && !held.is_trg && !cond.trig_capable)
      |=> get_dropped && exec_ok && !err_valid)
      else $error("Bus trigger on a device without triggers not dropped.");

   a_code_idle: assert property (
      !err_valid |-> err_code == `CODE_NONE && esr_set == `ESR_NONE)
      else $error("Code or status shown without an execution error.");

   a_pulse_once: assert property (
      err_valid |=> !err_valid)
      else $error("Execution error held for more than one cycle.");

endmodule // execution_error_classifier

/* File: exec_cfg.svh */
// Constants for the execution error classifier: error codes, status bit, widths.
// Assumes inclusion by bare name from every file that needs a code or a field position.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// ****************************************************************
// Code and status layout
// ****************************************************************
`define CODE_W          16
`define ESR_W           8
`define ESR_EXEC_BIT    4
`define ESR_NONE        8'h00
`define ESR_EXEC_MASK   8'h10
`define CODE_NONE       16'h0000
`define CODE_MIN        16'hFED5
`define CODE_MAX        16'hFF38
`define CODE_GENERIC    16'hFF38
`define CODE_LOCAL      16'hFF37
`define CODE_PROTECTED  16'hFF35
`define CODE_TRIG_IGN   16'hFF2D
`define CODE_INIT_IGN   16'hFF2B
`define CODE_PARAM      16'hFF24
`define CODE_CONFLICT   16'hFF23
`define CODE_RANGE      16'hFF22
`define CODE_ILLEGAL    16'hFF20

`endif

/* File: exec_pkg.sv */
// Types shared by the classifier and its code picker.
// Assumes exec_cfg.svh is on the include path.
`include "exec_cfg.svh"

package exec_pkg;

   // Per-message facts, latched when the parsed message is taken.
   typedef struct packed {
      logic is_get;          // Bus trigger message.
      logic is_trg;          // Common trigger command.
      logic is_trig_sig;     // Hardware trigger signal.
      logic is_init;         // Measurement start request.
      logic local_blocked;   // Would change a front panel setting.
      logic pw_protected;    // Command sits behind a password.
      logic param_conflict;  // Parameter clashes with present state.
      logic param_range;     // Parameter outside its legal range.
      logic param_list;      // Parameter matches no listed choice.
      logic param_other;     // Parameter fault of no finer kind.
      logic device_cond;     // Any other condition that stops execution.
   } exec_req_t;

   // Instrument levels, sampled when evaluation completes.
   typedef struct packed {
      logic hard_local;      // Held in local by a hard control.
      logic cmd_enabled;     // Protected commands are unlocked.
      logic trig_capable;    // Instrument has trigger capability.
      logic trig_ready;      // Ready to act on a trigger.
      logic meas_busy;       // A measurement is running.
   } exec_cond_t;

   // Classification result of one message.
   typedef struct packed {
      logic                 exec_err;
      logic                 cmd_err;
      logic                 get_dropped;
      logic [`CODE_W-1:0]   code;
   } exec_verdict_t;

endpackage

/* File: exec_code_picker.sv */
// Combinational code picker: maps one message and the instrument levels to a verdict.
// Assumes inputs are stable for the cycle in which the caller registers the result.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module exec_code_picker
(
   // Message and instrument state
   input  wire exec_pkg::exec_req_t     req,
   input  wire exec_pkg::exec_cond_t    cond,
   // Verdict
   output exec_pkg::exec_verdict_t      verdict
);

   // ****************************************************************
   // Condition decode
   // ****************************************************************

   // A device without trigger capability never sees a trigger as an execution matter.
   wire dt0_trg     = req.is_trg & ~cond.trig_capable;
   wire dt0_get     = req.is_get & ~cond.trig_capable;
   wire hit_local   = req.local_blocked & cond.hard_local;
   wire hit_prot    = req.pw_protected & ~cond.cmd_enabled;
   wire any_trig    = req.is_get | req.is_trg | req.is_trig_sig;
   wire hit_trig    = any_trig & cond.trig_capable & ~cond.trig_ready;
   wire hit_init    = req.is_init & cond.meas_busy;
   wire hit_param   = req.param_conflict | req.param_range | req.param_list
                      | req.param_other;
   wire hit_any     = hit_local | hit_prot | hit_trig | hit_init | hit_param
                      | req.device_cond;

   // Most specific first; the generic code is the last resort.
   wire [`CODE_W-1:0] pick =
      hit_local          ? `CODE_LOCAL     :
      hit_prot           ? `CODE_PROTECTED :
      hit_trig           ? `CODE_TRIG_IGN  :
      hit_init           ? `CODE_INIT_IGN  :
      req.param_conflict ? `CODE_CONFLICT  :
      req.param_range    ? `CODE_RANGE     :
      req.param_list     ? `CODE_ILLEGAL   :
      req.param_other    ? `CODE_PARAM     :
                           `CODE_GENERIC;

   // A command error takes the event whole, so no execution code comes with it.
   assign verdict.cmd_err     = dt0_trg;
   assign verdict.get_dropped = dt0_get;
   assign verdict.exec_err    = hit_any & ~dt0_trg & ~dt0_get;
   assign verdict.code        = verdict.exec_err ? pick : `CODE_NONE;

endmodule // exec_code_picker

/* File: host_model.sv */
// Behavioural remote host that offers parsed program messages to the classifier.
// Assumes the caller enters send just after a rising edge of mclk.
`timescale 1ns/1ps

module host_model
(
   // Clock
   input  wire                  mclk,
   // Message offer
   output logic                 req_valid,
   output exec_pkg::exec_req_t  req
);
   // ********************
   // Offer
   // ********************
   // Lines start quiet before the first message.
   initial
   begin
      req_valid = 1'b0;
      req       = '0;
   end

   // Offers one message after gap idle cycles and holds it for one edge only.
   // Released facts show the inverse, so a stale message is never read as fresh.
   task automatic send(input exec_pkg::exec_req_t msg, input int gap);
      repeat (gap) @(posedge mclk);
      if (gap > 0) #1;
      req_valid = 1'b1;
      req       = msg;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      req       = ~msg;
   endtask
endmodule // host_model

/* File: execution_error_classifier_tb_top.sv */
// Self-checking bench for the execution error classifier.
// Assumes the design files and host_model.sv are compiled before it.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module execution_error_classifier_tb_top;
   // ********************
   // Signals and instances
   // ********************
   typedef struct {logic [10:0] r; logic [4:0] c; int code;} row_t;
   logic                  mclk = 1'b0;
   logic                  rst_b = 1'b0;
   logic                  eval_done = 1'b0;
   logic                  req_valid, busy, err_valid, cmd_err, get_dropped, exec_ok;
   exec_pkg::exec_req_t   req;
   exec_pkg::exec_cond_t  cond = 5'h0E;
   logic [`CODE_W-1:0]    err_code, cap_code;
   logic [`ESR_W-1:0]     esr_set, cap_esr;
   int                    errors = 0, checks = 0, cycles = 0, n_err, n_cmd, n_drop, n_ok;
   // Facts, levels and expected code; rows past 10 stack faults to test ranking.
   row_t rows [17] = '{
      '{11'h040, 5'h1E, -201},
      '{11'h020, 5'h06, -203},
      '{11'h400, 5'h0C, -211},
      '{11'h200, 5'h0C, -211},
      '{11'h100, 5'h0C, -211},
      '{11'h080, 5'h0F, -213},
      '{11'h010, 5'h0E, -221},
      '{11'h008, 5'h0E, -222},
      '{11'h004, 5'h0E, -224},
      '{11'h002, 5'h0E, -220},
      '{11'h001, 5'h0E, -200},
      '{11'h07F, 5'h17, -201},
      '{11'h03F, 5'h17, -203},
      '{11'h11F, 5'h0D, -211},
      '{11'h09F, 5'h0F, -213},
      '{11'h01F, 5'h0E, -221},
      '{11'h006, 5'h0E, -224}};

   host_model host (.mclk(mclk), .req_valid(req_valid), .req(req));
   execution_error_classifier uut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
      .req(req), .eval_done(eval_done), .cond(cond), .busy(busy), .err_valid(err_valid),
      .err_code(err_code), .esr_set(esr_set), .cmd_err(cmd_err),
      .get_dropped(get_dropped), .exec_ok(exec_ok));

   // Clock of 50 ns.
   always #25 mclk = ~mclk;

   // A hang counts as a mismatch and still reaches the closing report.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         errors++;
         complete_run();
      end
   end

   // ********************
   // Compare and drive tasks
   // ********************
   task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_esr(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits ew cycles with no verdict allowed, then ends evaluation and counts pulses.
   task automatic finish(input int ew);
      repeat (ew)
      begin
         @(posedge mclk);
         #1;
         chk_flag(err_valid | exec_ok, 1'b0);
      end
      eval_done = 1'b1;
      @(posedge mclk);
      #1;
      eval_done = 1'b0;
      {n_err, n_cmd, n_drop, n_ok} = '0;
      repeat (4)
      begin
         if (err_valid === 1'b1)
         begin
            cap_code = err_code;
            cap_esr  = esr_set;
         end
         else
            chk_code(err_code, 16'h0000);
         n_err  += (err_valid === 1'b1);
         n_cmd  += (cmd_err === 1'b1);
         n_drop += (get_dropped === 1'b1);
         n_ok   += (exec_ok === 1'b1);
         @(posedge mclk);
         #1;
      end
      chk_flag(busy, 1'b0);
   endtask

   task automatic run(input logic [10:0] r, input logic [4:0] c, input int ew);
      cond = c;
      host.send(r, 0);
      finish(ew);
   endtask

   task automatic expect_err(input int code);
      chk_code(16'(n_err), 16'h0001);
      chk_code(cap_code, 16'(code));
      chk_esr(cap_esr, 8'h10);
      chk_code(16'(n_cmd + n_drop + n_ok), 16'h0000);
   endtask

   task automatic expect_none(input int ok, input int cmd, input int drop);
      chk_code(16'(n_err), 16'h0000);
      chk_code(16'(n_ok), 16'(ok));
      chk_code(16'(n_cmd), 16'(cmd));
      chk_code(16'(n_drop), 16'(drop));
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic t_codes();
      for (int k = 0; k < 11; k++)
      begin
         run(rows[k].r, rows[k].c, 0);
         expect_err(rows[k].code);
      end
      $display("t_codes done");
   endtask

   task automatic t_priority();
      for (int k = 11; k < 17; k++)
      begin
         run(rows[k].r, rows[k].c, 1);
         expect_err(rows[k].code);
      end
      $display("t_priority done");
   endtask

   task automatic t_no_trigger();
      run(11'h408, 5'h08, 0);
      expect_none(1, 0, 1);
      run(11'h240, 5'h18, 0);
      expect_none(0, 1, 0);
      run(11'h100, 5'h08, 0);
      expect_none(1, 0, 0);
      $display("t_no_trigger done");
   endtask

   task automatic t_clean();
      run(11'h040, 5'h0E, 6);
      expect_none(1, 0, 0);
      run(11'h400, 5'h0E, 0);
      expect_none(1, 0, 0);
      $display("t_clean done");
   endtask

   // A second offer while busy must leave the first verdict alone.
   task automatic t_refused();
      cond = 5'h0E;
      host.send(11'h008, 0);
      host.send(11'h004, 1);
      finish(1);
      expect_err(-222);
      $display("t_refused done");
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence: two cycles of reset, then every scenario in turn.
   initial
   begin
      repeat (2) @(posedge mclk);
      #1;
      chk_code(err_code, 16'h0000);
      rst_b = 1'b1;
      t_codes();
      t_priority();
      t_no_trigger();
      t_clean();
      t_refused();
      complete_run();
   end
endmodule // execution_error_classifier_tb_top
